// file: hdl/lsd_pkg.sv
/*
 * shared constants and types for the multiplexed lcd segment driver:
 * serial slave address, command byte layout, frame and blink dividers.
 * assumes a single system clock; the lcd oscillator arrives as a pin.
 */
package lsd_pkg;

    // display geometry
    localparam int          SEG_N        = 32;    // segment outputs
    localparam int          BP_N         = 4;     // backplane outputs
    localparam int          FIFO_W       = 9;     // {first, byte}
    localparam int          FIFO_D       = 16;    // words in the byte queue

    // serial slave address, hardware subaddress tied to zero
    localparam logic [2:0]  SUBADDR      = 3'h0;
    localparam logic [7:0]  ADDR_WR      = {4'h7, SUBADDR, 1'b0};

    // command byte fields
    localparam int          CMD_CONT_BIT = 7;     // another command follows
    localparam int          CMD_OP_HI    = 6;     // opcode msb
    localparam int          CMD_OP_LO    = 5;     // opcode lsb
    localparam logic [1:0]  OP_POINTER   = 2'h0;  // bits 4:0 address
    localparam logic [1:0]  OP_MODE      = 2'h1;  // bit 3 enable, 1:0 mux
    localparam logic [1:0]  OP_BANK      = 2'h2;  // bit 1 in, bit 0 out
    localparam logic [1:0]  OP_BLINK     = 2'h3;  // bit 2 alt, 1:0 rate
    localparam int          MODE_EN_BIT  = 3;
    localparam int          BANK_IN_BIT  = 1;
    localparam int          BLINK_ALT_BIT = 2;

    // timing, in lcd oscillator periods
    localparam logic [4:0]  FRAME_DIV    = 5'h18; // 24 periods a frame
    localparam logic [4:0]  SLOT2        = 5'h0c; // phase length, 1:2
    localparam logic [4:0]  SLOT3        = 5'h08; // phase length, 1:3
    localparam logic [4:0]  SLOT4        = 5'h06; // phase length, 1:4
    localparam int          NOM_OSC_HZ   = 1536;  // nominal lcd oscillator
    localparam logic [10:0] BLINK_HALF1  = 11'h180; // half of 768
    localparam logic [10:0] BLINK_HALF2  = 11'h300; // half of 1536
    localparam logic [10:0] BLINK_HALF3  = 11'h600; // half of 3072

    // reset values
    localparam logic [4:0]  PTR_RST      = 5'h00;
    localparam logic        EN_RST       = 1'b0;

    // drive modes: one to four active backplanes
    typedef enum logic [1:0] {MUX_STATIC, MUX_2, MUX_3, MUX_4} lsd_mux_e;

    // serial receiver states
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_DATA, I_DACK
    } lsd_i2c_e;

endpackage

// file: hdl/lsd_driver.sv
/*
 * lcd segment driver: write-only serial slave, byte queue, 32 x 4 display
 * memory, display latch, frame and blink timing, segment and backplane
 * waveforms as logic levels. holds the queue module and the top module.
 * assumes scl, sda and the lcd oscillator are asynchronous pins and that
 * the sda wire is resolved outside from the output enable.
 */
// How it works
// - display memory is 32 words of 4 bits
// - word bit n drives segments during backplane n
// - frame equals lcd oscillator divided by 24
// - 32 segment outputs from phase and latch
// - latch holds memory copy during each frame
// - three-phase mode: backplane 3 copies backplane 1
// - two-phase mode: backplanes 0=2 and 1=3
// - static mode: all backplanes identical
// - data goes to auto-incrementing pointer location
// - static output bank shows bit 2
// - two-phase output bank shows bits 2, 3
// - input bank steers writes, independent of output
// - blink off or oscillator over 768/1536/3072
// - static/two-phase blink alternates between both banks
// - enable bit blanks display, host may toggle
// - nominal rates assume 1536 Hz oscillator
// - slave receiver only, subaddress fixed zero
// - recognises write address byte 0111 0000
// - read accesses are never acknowledged
// - one to four backplanes, 32 to 128 elements
`timescale 1ns/100ps

// synchronous fifo with valid and ready on both sides
module lsd_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    // whole queue state
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;   // storage words
        logic [AW-1:0]       wp;    // write index
        logic [AW-1:0]       rp;    // read index
        logic [AW:0]         cnt;   // words held
    } lsd_fifo_s;

    lsd_fifo_s st;
    lsd_fifo_s next_st;

    logic push;
    logic pop;

    // honest full and empty
    assign in_ready  = (st.cnt != (AW+1)'(D));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next queue state
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp         = AW'(st.wp + AW'(1));
        end
        if (pop) begin
            next_st.rp = AW'(st.rp + AW'(1));
        end
        next_st.cnt = (AW+1)'(st.cnt + (AW+1)'(push) - (AW+1)'(pop));
    end

    // register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

module lsd_driver (
    // clock, reset, enable
    input  wire logic              MCLK_I,
    input  wire logic              NRST_I,
    input  wire logic              CE_I,
    // serial bus pins
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_N_O,
    // lcd oscillator pin
    input  wire logic              LCD_OSC_I,
    // lcd drive levels
    output logic [31:0]            SEG_O,
    output logic [3:0]             BP_O,
    // status
    output logic                   DISP_EN_O,
    output lsd_pkg::lsd_mux_e      DISP_MUX_O,
    output logic                   QUEUE_FULL_O
);
    import lsd_pkg::*;

    // whole block state
    typedef struct packed {
        logic                  scl_s1, scl_s2, scl_p;  // scl sync
        logic                  sda_s1, sda_s2, sda_p;  // sda sync
        logic                  osc_s1, osc_s2, osc_p;  // oscillator sync
        lsd_i2c_e              i2c;     // receiver state
        logic [3:0]            bitc;    // bits of current byte
        logic [7:0]            sh;      // receive shifter
        logic                  first;   // next byte opens a transfer
        logic                  drive;   // pulling sda low
        logic                  push;    // queue write pulse
        logic [8:0]            pdata;   // queue write word
        logic                  cmd;     // bytes are commands
        logic [7:0]            wbyte;   // data byte being unpacked
        logic [3:0]            wleft;   // words still to write
        logic [4:0]            ptr;     // data pointer
        logic                  en;      // display enable
        lsd_mux_e              mux;     // drive mode
        logic                  ibank;   // input bank
        logic                  obank;   // output bank
        logic [1:0]            bfreq;   // blink rate, 0 off
        logic                  balt;    // blink by bank swap
        logic [31:0][3:0]      ram;     // display memory
        logic [31:0][3:0]      latch;   // display latch
        logic [4:0]            fcnt;    // oscillator periods in frame
        logic                  pol;     // frame polarity
        logic [10:0]           bcnt;    // blink half-period count
        logic                  bph;     // blink phase
        logic [31:0]           seg;     // segment levels
        logic [3:0]            bp;      // backplane levels
    } lsd_s;

    lsd_s        st;
    lsd_s        next_st;

    // queue wiring
    logic        q_in_ready;
    logic        q_out_valid;
    logic        q_out_ready;
    logic [8:0]  q_out_data;

    // per-cycle helpers
    logic        scl_rise, scl_fall, sda_rise, sda_fall, osc_tick;
    logic [1:0]  phase;
    logic [1:0]  rd_bit;
    logic        alt_ok, swap, blank;
    logic [10:0] bhalf;
    logic        cm;
    logic [7:0]  qb;

    // byte queue between receiver and unpacker
    lsd_fifo #(.W(FIFO_W), .D(FIFO_D)) u_queue (
        .clk       (MCLK_I),
        .rst_n     (NRST_I),
        .ce        (CE_I),
        .in_valid  (st.push),
        .in_ready  (q_in_ready),
        .in_data   (st.pdata),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_out_data)
    );

    // unpacker stalls the queue while a byte is being spread out
    assign q_out_ready = (st.wleft == 4'h0);

    // edges from the second synchroniser stage only
    assign scl_rise = st.scl_s2 && !st.scl_p;
    assign scl_fall = !st.scl_s2 && st.scl_p;
    assign sda_rise = st.sda_s2 && !st.sda_p;
    assign sda_fall = !st.sda_s2 && st.sda_p;
    assign osc_tick = st.osc_s2 && !st.osc_p;

    // outputs
    assign SDA_O        = 1'b0;
    assign SDA_OE_N_O   = !st.drive;
    assign SEG_O        = st.seg;
    assign BP_O         = st.bp;
    assign DISP_EN_O    = st.en;
    assign DISP_MUX_O   = st.mux;
    assign QUEUE_FULL_O = !q_in_ready;

    // next state of the whole block
    always_comb begin
        next_st = st;
        cm      = 1'b0;
        qb      = q_out_data[7:0];
        phase   = 2'h0;
        rd_bit  = 2'h0;
        alt_ok  = 1'b0;
        swap    = 1'b0;
        blank   = 1'b0;
        bhalf   = BLINK_HALF1;

        // two-stage synchronisers and edge history
        next_st.scl_s1 = SCL_I;
        next_st.scl_s2 = st.scl_s1;
        next_st.scl_p  = st.scl_s2;
        next_st.sda_s1 = SDA_I;
        next_st.sda_s2 = st.sda_s1;
        next_st.sda_p  = st.sda_s2;
        next_st.osc_s1 = LCD_OSC_I;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_p  = st.osc_s2;
        next_st.push   = 1'b0;

        // serial slave receiver
        if (st.scl_s2 && sda_fall) begin
            // start or repeated start
            next_st.i2c   = I_ADDR;
            next_st.bitc  = 4'h0;
            next_st.first = 1'b1;
            next_st.drive = 1'b0;
        end else if (st.scl_s2 && sda_rise) begin
            // stop
            next_st.i2c   = I_IDLE;
            next_st.drive = 1'b0;
        end else begin
            unique case (st.i2c)
                I_IDLE: begin
                end
                I_ADDR, I_DATA: begin
                    if (scl_rise) begin
                        next_st.sh   = {st.sh[6:0], st.sda_s2};
                        next_st.bitc = 4'(st.bitc + 4'h1);
                    end else if (scl_fall && st.bitc == 4'h8) begin
                        next_st.bitc = 4'h0;
                        if (st.i2c == I_ADDR) begin
                            if (st.sh == ADDR_WR) begin
                                next_st.drive = 1'b1;
                                next_st.i2c   = I_AACK;
                            end else begin
                                next_st.i2c   = I_IDLE;
                            end
                        end else if (q_in_ready) begin
                            // queue the byte, acknowledge it
                            next_st.push  = 1'b1;
                            next_st.pdata = {st.first, st.sh};
                            next_st.first = 1'b0;
                            next_st.drive = 1'b1;
                            next_st.i2c   = I_DACK;
                        end else begin
                            // queue full: no acknowledge, drop transfer
                            next_st.i2c   = I_IDLE;
                        end
                    end
                end
                I_AACK, I_DACK: begin
                    // release after the acknowledge clock
                    if (scl_fall) begin
                        next_st.drive = 1'b0;
                        next_st.i2c   = I_DATA;
                    end
                end
            endcase
        end

        // unpacker: spread one data byte over memory words
        if (st.wleft != 4'h0) begin
            next_st.wleft = 4'(st.wleft - 4'h1);
            next_st.ptr   = 5'(st.ptr + 5'h1);
            unique case (st.mux)
                MUX_STATIC: begin
                    next_st.ram[st.ptr][{st.ibank, 1'b0}] = st.wbyte[7];
                    next_st.wbyte = {st.wbyte[6:0], 1'b0};
                end
                MUX_2: begin
                    next_st.ram[st.ptr][{st.ibank, 1'b1}] = st.wbyte[7];
                    next_st.ram[st.ptr][{st.ibank, 1'b0}] = st.wbyte[6];
                    next_st.wbyte = {st.wbyte[5:0], 2'h0};
                end
                MUX_3, MUX_4: begin
                    next_st.ram[st.ptr] = st.wbyte[7:4];
                    next_st.wbyte = {st.wbyte[3:0], 4'h0};
                end
            endcase
        end else if (q_out_valid) begin
            // first byte of a transfer is a command
            cm = q_out_data[8] || st.cmd;
            if (cm) begin
                next_st.cmd = qb[CMD_CONT_BIT];
                unique case (qb[CMD_OP_HI:CMD_OP_LO])
                    OP_POINTER: next_st.ptr = qb[4:0];
                    OP_MODE: begin
                        next_st.en  = qb[MODE_EN_BIT];
                        next_st.mux = lsd_mux_e'(qb[1:0]);
                    end
                    OP_BANK: begin
                        next_st.ibank = qb[BANK_IN_BIT];
                        next_st.obank = qb[0];
                    end
                    OP_BLINK: begin
                        next_st.balt  = qb[BLINK_ALT_BIT];
                        next_st.bfreq = qb[1:0];
                    end
                endcase
            end else begin
                next_st.wbyte = qb;
                unique case (st.mux)
                    MUX_STATIC: next_st.wleft = 4'h8;
                    MUX_2:      next_st.wleft = 4'h4;
                    MUX_3,
                    MUX_4:      next_st.wleft = 4'h2;
                endcase
            end
        end

        if (osc_tick) begin
            if (st.fcnt == FRAME_DIV - 5'h1) begin
                next_st.fcnt  = 5'h0;
                next_st.pol   = !st.pol;
                next_st.latch = st.ram;
            end else begin
                next_st.fcnt  = 5'(st.fcnt + 5'h1);
            end
        end

        // half periods for 2, 1, 0.5 Hz at nominal rate
        unique case (st.bfreq)
            2'h1:    bhalf = BLINK_HALF1;
            2'h2:    bhalf = BLINK_HALF2;
            default: bhalf = BLINK_HALF3;
        endcase
        if (st.bfreq == 2'h0) begin
            next_st.bcnt = 11'h0;
            next_st.bph  = 1'b0;
        end else if (osc_tick) begin
            if (st.bcnt >= bhalf - 11'h1) begin
                next_st.bcnt = 11'h0;
                next_st.bph  = !st.bph;
            end else begin
                next_st.bcnt = 11'(st.bcnt + 11'h1);
            end
        end

        // multiplex phase within the frame
        unique case (st.mux)
            MUX_STATIC: phase = 2'h0;
            MUX_2:      phase = (st.fcnt >= SLOT2) ? 2'h1 : 2'h0;
            MUX_3:      phase = (st.fcnt >= 5'(2 * SLOT3)) ? 2'h2 :
                                (st.fcnt >= SLOT3) ? 2'h1 : 2'h0;
            MUX_4:      phase = (st.fcnt >= 5'(3 * SLOT4)) ? 2'h3 :
                                (st.fcnt >= 5'(2 * SLOT4)) ? 2'h2 :
                                (st.fcnt >= SLOT4) ? 2'h1 : 2'h0;
        endcase

        // bank swap blinking in static and two-phase
        alt_ok = st.balt && (st.mux == MUX_STATIC || st.mux == MUX_2);
        swap   = alt_ok && st.bph;
        unique case (st.mux)
            MUX_STATIC: rd_bit = {st.obank ^ swap, 1'b0};
            MUX_2:      rd_bit = {st.obank ^ swap, phase[0]};
            MUX_3,
            MUX_4:      rd_bit = phase;
        endcase
        // whole display blank only when asked
        blank = !st.en || (st.bfreq != 2'h0 && !alt_ok && st.bph);

        // segment levels, on is opposite the active backplane
        for (int i = 0; i < SEG_N; i++) begin
            next_st.seg[i] = (!blank && st.latch[i][rd_bit]) ? st.pol
                                                              : !st.pol;
        end
        for (int k = 0; k < BP_N; k++) begin
            unique case (st.mux)
                MUX_STATIC: next_st.bp[k] = !st.pol;
                MUX_2:      next_st.bp[k] = (k[0] == phase[0]) ^ st.pol;
                MUX_3:      next_st.bp[k] = ((k == 3 ? 2'h1 : 2'(k))
                                             == phase) ^ st.pol;
                MUX_4:      next_st.bp[k] = (2'(k) == phase) ^ st.pol;
            endcase
        end
    end

    // memory lives in the registered state
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st       <= '0;
            st.scl_s1 <= 1'b1;
            st.scl_s2 <= 1'b1;
            st.scl_p  <= 1'b1;
            st.sda_s1 <= 1'b1;
            st.sda_s2 <= 1'b1;
            st.sda_p  <= 1'b1;
            st.ptr    <= PTR_RST;
            st.en     <= EN_RST;
            st.i2c    <= I_IDLE;
            st.mux    <= MUX_STATIC;
        end else if (CE_I) begin
            st <= next_st;
        end
    end

    // address acknowledge only for the write address
    property p_addr_ack;
        @(posedge MCLK_I) disable iff (!NRST_I)
        (st.i2c == I_AACK && $past(st.i2c) == I_ADDR) |-> st.sh == ADDR_WR;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledged for a foreign byte");

    property p_no_read;
        @(posedge MCLK_I) disable iff (!NRST_I)
        (st.i2c == I_ADDR && st.bitc == 4'h8 && st.sh[0] && scl_fall
         && CE_I && !(st.scl_s2 && (sda_fall || sda_rise)))
        |=> st.i2c == I_IDLE && SDA_OE_N_O;
    endproperty
    a_no_read: assert property (p_no_read)
        else $error("read access was acknowledged");

    property p_static_bp;
        @(posedge MCLK_I) disable iff (!NRST_I)
        ($past(st.mux) == MUX_STATIC && st.mux == MUX_STATIC)
        |-> (BP_O == 4'h0 || BP_O == 4'hf);
    endproperty
    a_static_bp: assert property (p_static_bp)
        else $error("static backplanes differ");

    property p_two_bp;
        @(posedge MCLK_I) disable iff (!NRST_I)
        ($past(st.mux) == MUX_2) |-> (BP_O[0] == BP_O[2] &&
                                      BP_O[1] == BP_O[3] &&
                                      BP_O[0] != BP_O[1]);
    endproperty
    a_two_bp: assert property (p_two_bp)
        else $error("two-phase backplane pairs differ");

    property p_three_bp;
        @(posedge MCLK_I) disable iff (!NRST_I)
        ($past(st.mux) == MUX_3) |-> BP_O[3] == BP_O[1];
    endproperty
    a_three_bp: assert property (p_three_bp)
        else $error("backplane 3 differs from backplane 1");

    // polarity turns only at the 24th oscillator edge
    property p_frame;
        @(posedge MCLK_I) disable iff (!NRST_I)
        $changed(st.pol) |-> ($past(st.fcnt) == FRAME_DIV - 5'h1
                              && $past(osc_tick) && st.fcnt == 5'h0);
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame polarity turned off the 24 count");

    // each word written advances the pointer by one
    property p_ptr_inc;
        @(posedge MCLK_I) disable iff (!NRST_I)
        (st.wleft != 4'h0 && CE_I) |=> st.ptr == 5'($past(st.ptr) + 5'h1);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc)
        else $error("pointer failed to advance");

    // blink phase turns only after a full half period
    property p_blink;
        @(posedge MCLK_I) disable iff (!NRST_I)
        ($changed(st.bph) && st.bfreq != 2'h0)
        |-> $past(st.bcnt) >= $past(bhalf) - 11'h1;
    endproperty
    a_blink: assert property (p_blink)
        else $error("blink phase turned early");

    // disabled display shows no segment contrast
    property p_blank;
        @(posedge MCLK_I) disable iff (!NRST_I)
        ($past(CE_I) && $past(NRST_I) && !$past(st.en))
        |-> SEG_O == {32{!$past(st.pol)}};
    endproperty
    a_blank: assert property (p_blank)
        else $error("segments driven while display disabled");
endmodule

// file: verif/lsd_i2c_host.sv
/* serial bus master model for the lcd driver bench.
 * assumes the bench resolves the open drain data wire. */
`timescale 1ns/100ps
module lsd_i2c_host (
    // clock and resolved data wire
    input  wire logic clk,
    input  wire logic sda_i,
    // driven levels
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // each level stands six clocks
    task automatic q();
        repeat (6) @(negedge clk);
    endtask
    // start, also repeated start
    task automatic start();
        sda_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_o = 1'b0;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_o = 1'b1;
        q();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_o = (i > 0) ? b[i-1] : 1'b1;
            q();
            scl_o = 1'b1;
            q();
            ack = (sda_i === 1'b0);
            q();
            scl_o = 1'b0;
            q();
        end
    endtask
endmodule

// file: verif/lsd_driver_tb_top.sv
/* lcd driver bench top: serial writes, drive level checks.
 * assumes the master model and a 10 MHz lcd oscillator. */
`timescale 1ns/100ps
module lsd_driver_tb_top;
    import lsd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        osc = 1'b0;
    logic        scl, sda_m, sda_o, sda_oe_n, en, full, ack;
    wire         sda;
    logic [31:0] seg;
    logic [3:0]  bp;
    lsd_mux_e    mux;
    logic [3:0]  w [32];
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;
    always #5 clk = ~clk;
    always #50 osc = ~osc;
    // open drain data wire
    assign sda = sda_m & (sda_oe_n | sda_o);
    lsd_i2c_host i_lsd_i2c_host (.clk(clk), .sda_i(sda), .scl_o(scl),
        .sda_o(sda_m));
    lsd_driver i_lsd_driver (.MCLK_I(clk), .NRST_I(rst_n), .CE_I(ce),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .LCD_OSC_I(osc), .SEG_O(seg), .BP_O(bp), .DISP_EN_O(en),
        .DISP_MUX_O(mux), .QUEUE_FULL_O(full));
    task automatic report_and_stop();
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input bit ok);
        compares++;
        if (!ok) begin
            $display("[FAIL] %0t display or ack mismatch", $time);
            fail_count++;
        end
    endtask
    task automatic send(input logic [7:0] b, input bit exp);
        i_lsd_i2c_host.wbyte(b, ack);
        chk(ack === exp);
    endtask
    // every segment against the model memory for one backplane
    task automatic chk_seg(input int k, input logic d);
        foreach (w[j]) begin
            chk(seg[j] === (w[j][k] ^ d));
        end
    endtask
    // static bank select: write bit 2 of words 4..11, then show it
    task automatic t_bank();
        i_lsd_i2c_host.start();
        send(ADDR_WR, 1'b1);
        send(8'hc3, 1'b1);
        send(8'h04, 1'b1);
        send(8'hf0, 1'b1);
        i_lsd_i2c_host.stop();
        for (int j = 4; j < 8; j++) w[j][2] = 1'b1;
        repeat (300) @(negedge clk);
        chk_seg(2, seg[2]);
    endtask
    // whole-display blink at the fastest rate, then off again
    task automatic t_blink();
        int   n, ph;
        logic l, lp;
        i_lsd_i2c_host.start();
        send(ADDR_WR, 1'b1);
        send(8'h61, 1'b1);
        i_lsd_i2c_host.stop();
        ph = 0;
        n  = 0;
        lp = 1'b1;
        repeat (8000) begin
            @(negedge clk);
            l = (seg[4] !== seg[2]);
            n++;
            if (lp && !l) begin
                ph = 1;
                n  = 0;
            end
            if (!lp && l && ph == 1) begin
                chk(n >= 3839 && n <= 3841);
                ph = 2;
            end
            lp = l;
        end
        chk(ph == 2);
        i_lsd_i2c_host.start();
        send(ADDR_WR, 1'b1);
        send(8'h60, 1'b1);
        i_lsd_i2c_host.stop();
        repeat (20) @(negedge clk);
        chk(seg[4] !== seg[2]);
    endtask
    // clock enable low freezes the segment and backplane levels
    task automatic t_freeze();
        logic [31:0] s;
        logic [3:0]  b;
        s  = seg;
        b  = bp;
        ce = 1'b0;
        repeat (500) @(negedge clk);
        chk(seg === s && bp === b);
        ce = 1'b1;
    endtask
    // mode set, enabled, then watch the levels
    task automatic t_mode(input lsd_mux_e m);
        logic d, dp;
        int   n, seen;
        i_lsd_i2c_host.start();
        send(ADDR_WR, 1'b1);
        send(8'h28 | 8'(m), 1'b1);
        i_lsd_i2c_host.stop();
        repeat (600) @(negedge clk);
        chk(mux === m && en === 1'b1);
        chk(full === 1'b0);
        seen = 0;
        n = 0;
        dp = seg[2];
        repeat (800) begin
            @(negedge clk);
            d = seg[2];
            n++;
            if (d !== dp) begin
                if (seen) chk(n >= 239 && n <= 241);
                seen = 1;
                n = 0;
            end
            dp = d;
            case (m)
                MUX_STATIC: chk(bp === {4{bp[0]}});
                MUX_2: chk(bp[0] === bp[2] && bp[1] === bp[3]);
                MUX_3: chk(bp[3] === bp[1]);
                default: begin
                    chk($countones(bp ~^ {4{d}}) == 1);
                    for (int k = 0; k < 4; k++) begin
                        if (bp[k] === d) chk_seg(k, d);
                    end
                end
            endcase
        end
    endtask
    initial begin
        foreach (w[j]) w[j] = 4'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        i_lsd_i2c_host.start();
        send(8'h71, 1'b0);
        i_lsd_i2c_host.start();
        send(8'h72, 1'b0);
        t_mode(MUX_4);
        i_lsd_i2c_host.start();
        send(ADDR_WR, 1'b1);
        send(8'h1e, 1'b1);
        send(8'ha5, 1'b1);
        send(8'h3c, 1'b1);
        i_lsd_i2c_host.stop();
        w[30] = 4'ha;
        w[31] = 4'h5;
        w[0] = 4'h3;
        w[1] = 4'hc;
        t_mode(MUX_4);
        t_mode(MUX_STATIC);
        t_bank();
        t_blink();
        t_freeze();
        t_mode(MUX_2);
        t_mode(MUX_3);
        report_and_stop();
    end
endmodule
